// ===== core/fcpwm_regs.vh
// Register map, field positions and reset values of the PWM block
`ifndef FCPWM_REGS_VH
`define FCPWM_REGS_VH
// Register indices; byte address is four times the index
`define FCPWM_IDX_PERIOD_HIGH 8'hD1
`define FCPWM_IDX_DUTY0_HIGH 8'hD2
`define FCPWM_IDX_DUTY1_HIGH 8'hD3
`define FCPWM_IDX_DUTY2_HIGH 8'hD5
`define FCPWM_IDX_PERIOD_LOW 8'hD9
`define FCPWM_IDX_DUTY0_LOW 8'hDA
`define FCPWM_IDX_DUTY1_LOW 8'hDB
`define FCPWM_IDX_CONTROL0 8'hDC
`define FCPWM_IDX_DUTY2_LOW 8'hDD
`define FCPWM_IDX_DUTY3_LOW 8'hDE
`define FCPWM_IDX_DUTY3_HIGH 8'hD6
// Control register 0 fields
`define FCPWM_CTL_RUN 7
`define FCPWM_CTL_LOAD 6
`define FCPWM_CTL_CF 5
`define FCPWM_CTL_CLEAR 4
// Reset values and the all-ones duty value
`define FCPWM_RST_BYTE 8'h00
`define FCPWM_RST_WORD 10'h000
`define FCPWM_DUTY_ALL_ONES 10'h3FF
`endif

// ===== core/fcpwm_top.v
// Four-channel 10-bit PWM generator with an APB register slave
// Behaviour
// RQ1: Four output channels, 10-bit duty each, share one period counter.
// RQ2: After reset every internal channel output is high.
// RQ3: Software sets the port latch bit before a pin shows the output.
// RQ4: A 10-bit down counter is clocked by the prescaled system clock.
// RQ5: On underflow the counter reloads the buffered period and continues.
// RQ6: Rate is counter clock over one plus period; duty is duty over that.
// RQ7: Period low eight bits in low register, bits 9:8 in high bits 1:0.
// RQ8: Duty low eight bits in low register, bits 9:8 in high bits 1:0.
// RQ9: The counter-clear bit 4 of control 0 forces the counter known.
// RQ10: Run bit 7 of control 0 starts the down counter.
// RQ11: Output high while counter not below duty, then low until underflow.
// RQ12: Period and duty are double buffered; load bit plus period end applies.
// RQ13: Software clears counter, writes period and duties, then sets run.
// RQ14: Writing one to the counter-clear bit sets the counter to zero.
// RQ15: After the underflow transfer hardware clears the load bit next cycle; the code clears it at the same edge as the transfer.
// RQ16: Duty zero holds output high; duty all ones holds it low.
// RQ17: Each channel has an invert bit that complements its output.
// RQ18: The prescaler ratio is a static configuration input.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "fcpwm_regs.vh"
module fcpwm_top (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [7:0] prescale_ratio,
	output reg [3:0] channel_out
);

	// Holding (software) registers
	reg [9:0] period_hold_reg;
	reg [39:0] duty_hold_reg;
	reg [7:0] control_reg;
	// Working registers
	reg [9:0] period_work_reg;
	reg [39:0] duty_work_reg;
	reg [9:0] count_reg;
	reg [7:0] prescale_reg;
	reg [3:0] raw_reg;
	reg tick_reg;
	wire [7:0] index;
	wire setup;
	wire wr_strobe;
	wire mapped;
	wire underflow;

	// Map a register index to a valid flag
	function is_mapped;
		input [7:0] idx;
		begin
			case (idx)
				`FCPWM_IDX_PERIOD_HIGH, `FCPWM_IDX_DUTY0_HIGH, `FCPWM_IDX_DUTY1_HIGH,
				`FCPWM_IDX_DUTY2_HIGH, `FCPWM_IDX_DUTY3_HIGH, `FCPWM_IDX_PERIOD_LOW,
				`FCPWM_IDX_DUTY0_LOW, `FCPWM_IDX_DUTY1_LOW, `FCPWM_IDX_DUTY2_LOW,
				`FCPWM_IDX_DUTY3_LOW, `FCPWM_IDX_CONTROL0: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	// Word-aligned decode; upper address bits must be zero
	assign index = paddr[9:2];
	assign setup = psel && !penable;
	assign mapped = is_mapped(index) && (paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'h0);
	// Writes land only at the edge where the master sees pready high
	assign wr_strobe = psel && penable && pready && pwrite && mapped;
	// Underflow: tick while counting and already at zero
	assign underflow = control_reg[`FCPWM_CTL_RUN] && tick_reg && (count_reg == `FCPWM_RST_WORD); // RQ5

	// APB answer: one wait-free access phase after setup
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped;
			prdata <= 32'h00000000;
			if (setup && !pwrite && mapped) begin
				case (index)
					`FCPWM_IDX_PERIOD_HIGH: prdata <= {30'h00000000, period_hold_reg[9:8]};
					`FCPWM_IDX_PERIOD_LOW: prdata <= {24'h000000, period_hold_reg[7:0]};
					`FCPWM_IDX_DUTY0_HIGH: prdata <= {30'h00000000, duty_hold_reg[9:8]};
					`FCPWM_IDX_DUTY0_LOW: prdata <= {24'h000000, duty_hold_reg[7:0]};
					`FCPWM_IDX_DUTY1_HIGH: prdata <= {30'h00000000, duty_hold_reg[19:18]};
					`FCPWM_IDX_DUTY1_LOW: prdata <= {24'h000000, duty_hold_reg[17:10]};
					`FCPWM_IDX_DUTY2_HIGH: prdata <= {30'h00000000, duty_hold_reg[29:28]};
					`FCPWM_IDX_DUTY2_LOW: prdata <= {24'h000000, duty_hold_reg[27:20]};
					`FCPWM_IDX_DUTY3_HIGH: prdata <= {30'h00000000, duty_hold_reg[39:38]};
					`FCPWM_IDX_DUTY3_LOW: prdata <= {24'h000000, duty_hold_reg[37:30]};
					default: prdata <= {24'h000000, control_reg};
				endcase
			end
		end
	end

	// Holding registers written in the access phase, at the answer edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_hold_reg <= `FCPWM_RST_WORD;
			duty_hold_reg <= 40'h0000000000;
		end else if (wr_strobe) begin
			case (index)
				`FCPWM_IDX_PERIOD_HIGH: period_hold_reg[9:8] <= pwdata[1:0]; // RQ7
				`FCPWM_IDX_PERIOD_LOW: period_hold_reg[7:0] <= pwdata[7:0]; // RQ7
				`FCPWM_IDX_DUTY0_HIGH: duty_hold_reg[9:8] <= pwdata[1:0]; // RQ8
				`FCPWM_IDX_DUTY0_LOW: duty_hold_reg[7:0] <= pwdata[7:0]; // RQ8
				`FCPWM_IDX_DUTY1_HIGH: duty_hold_reg[19:18] <= pwdata[1:0];
				`FCPWM_IDX_DUTY1_LOW: duty_hold_reg[17:10] <= pwdata[7:0];
				`FCPWM_IDX_DUTY2_HIGH: duty_hold_reg[29:28] <= pwdata[1:0];
				`FCPWM_IDX_DUTY2_LOW: duty_hold_reg[27:20] <= pwdata[7:0];
				`FCPWM_IDX_DUTY3_HIGH: duty_hold_reg[39:38] <= pwdata[1:0];
				`FCPWM_IDX_DUTY3_LOW: duty_hold_reg[37:30] <= pwdata[7:0];
				default: period_hold_reg <= period_hold_reg;
			endcase
		end
	end

	// Control register; hardware set of the flag wins over software writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_reg <= `FCPWM_RST_BYTE;
		end else begin
			if (wr_strobe && index == `FCPWM_IDX_CONTROL0) begin
				control_reg <= pwdata[7:0];
			end else if (control_reg[`FCPWM_CTL_CLEAR]) begin
				// Clear bit acts once and then drops so it cannot hold the counter
				control_reg[`FCPWM_CTL_CLEAR] <= 1'b0;
			end
			if (underflow) begin
				control_reg[`FCPWM_CTL_CF] <= 1'b1;
				if (control_reg[`FCPWM_CTL_LOAD]) begin
					control_reg[`FCPWM_CTL_LOAD] <= 1'b0; // RQ15
				end
			end
		end
	end

	// Prescaler: one tick every prescale_ratio+1 system clocks
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale_reg <= `FCPWM_RST_BYTE;
			tick_reg <= 1'b0;
		end else if (!control_reg[`FCPWM_CTL_RUN]) begin
			prescale_reg <= `FCPWM_RST_BYTE;
			tick_reg <= 1'b0;
		end else if (prescale_reg >= prescale_ratio) begin // RQ18
			prescale_reg <= `FCPWM_RST_BYTE;
			tick_reg <= 1'b1; // RQ4
		end else begin
			prescale_reg <= prescale_reg + 8'h01;
			tick_reg <= 1'b0;
		end
	end

	// Shared down counter with reload and double-buffer transfer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= `FCPWM_RST_WORD;
			period_work_reg <= `FCPWM_RST_WORD;
			duty_work_reg <= 40'h0000000000;
		end else if (control_reg[`FCPWM_CTL_CLEAR]) begin
			count_reg <= `FCPWM_RST_WORD; // RQ9 RQ14
		end else if (underflow) begin
			if (control_reg[`FCPWM_CTL_LOAD]) begin
				// New values only at period end, so edges stay glitch free
				period_work_reg <= period_hold_reg; // RQ12
				duty_work_reg <= duty_hold_reg; // RQ12
				count_reg <= period_hold_reg;
			end else begin
				count_reg <= period_work_reg; // RQ5
			end
		end else if (control_reg[`FCPWM_CTL_RUN] && tick_reg) begin
			count_reg <= count_reg - 10'h001; // RQ10
		end
	end

	// Per-channel compare; holds its state while stopped
	genvar ch;
	generate
		for (ch = 0; ch < 4; ch = ch + 1) begin : g_chan
			wire [9:0] duty = duty_work_reg[ch*10+9:ch*10];
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					raw_reg[ch] <= 1'b1; // RQ2
					channel_out[ch] <= 1'b1; // RQ2
				end else begin
					if (control_reg[`FCPWM_CTL_RUN]) begin
						if (duty == `FCPWM_RST_WORD) begin
							raw_reg[ch] <= 1'b1; // RQ16
						end else if (duty == `FCPWM_DUTY_ALL_ONES) begin
							raw_reg[ch] <= 1'b0; // RQ16
						end else begin
							raw_reg[ch] <= (count_reg >= duty); // RQ11 RQ6 RQ1
						end
					end
					channel_out[ch] <= raw_reg[ch] ^ control_reg[ch]; // RQ17
				end
			end
		end
	endgenerate

endmodule // fcpwm_top

// ===== tb/fcpwm_properties.sv
// Port-level assertions and covers of the PWM block
`timescale 1ns/1ps
`include "fcpwm_regs.vh"
module fcpwm_properties (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [3:0] channel_out
);
	// Answer cycle of a read
	wire rd = pready && !pwrite;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rst; $rose(presetn) |-> channel_out == 4'hF; endproperty
	a_rst: assert property (p_rst) else $error("outputs low after reset");
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no answer after setup");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("answer held too long");
	property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("bad refusal");
	property p_quiet; !pready |-> prdata == 32'h0 && !pslverr; endproperty
	a_quiet: assert property (p_quiet) else $error("data outside answer");
	property p_phi; rd && paddr[9:2] == `FCPWM_IDX_PERIOD_HIGH |-> prdata[31:2] == 30'h0; endproperty
	a_phi: assert property (p_phi) else $error("period high too wide");
	// Duty high registers keep only two bits
	property p_dhi;
		rd && paddr[9:2] inside {`FCPWM_IDX_DUTY0_HIGH, `FCPWM_IDX_DUTY1_HIGH,
			`FCPWM_IDX_DUTY2_HIGH, `FCPWM_IDX_DUTY3_HIGH} |-> prdata[31:2] == 30'h0;
	endproperty
	a_dhi: assert property (p_dhi) else $error("duty high too wide");
	property p_ctl; rd && paddr[9:2] == `FCPWM_IDX_CONTROL0 |-> prdata[31:8] == 24'h0; endproperty
	a_ctl: assert property (p_ctl) else $error("control too wide");
	c_err: cover property (pslverr);
	c_rd: cover property (rd);
	c_fall: cover property ($fell(channel_out[2]));
endmodule // fcpwm_properties

// ===== tb/fcpwm_load.sv
// Load model counting high cycles on each PWM pin
`timescale 1ns/1ps
module fcpwm_load (
	input wire pclk,
	input wire clr,
	input wire [3:0] latch,
	input wire [3:0] channel_out,
	output logic [3:0][15:0] hi_cnt
);
	// Pin shows the block only where the port latch holds a one
	wire [3:0] pin = latch & channel_out;
	// Whole-period windows make the counts exact whatever the phase
	always @(posedge pclk) begin
		for (int i = 0; i < 4; i++) begin
			hi_cnt[i] <= clr ? 16'h0 : hi_cnt[i] + pin[i];
		end
	end
endmodule // fcpwm_load

// ===== tb/fcpwm_tb_top.sv
// Bench of the PWM block: register table, duty windows, double buffering
`timescale 1ns/1ps
`include "fcpwm_regs.vh"
module fcpwm_tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 0, e;
	logic [31:0] paddr = 0, pwdata = 0, prdata, r;
	logic pready, pslverr;
	logic [7:0] prescale_ratio = 8'h01;
	logic [3:0] channel_out, latch = 0;
	logic [3:0][15:0] hi_cnt;
	int failures = 0, samples_checked = 0, cyc = 0;
	// Index, byte written, byte read back
	logic [23:0] rows [11] = '{24'hD1FC00, 24'hD90909, 24'hD2FC00, 24'hDA0000, 24'hD3FF03,
		24'hDBFFFF, 24'hD50000, 24'hDD0303, 24'hD60000, 24'hDE0303, 24'hC05500};
	always #20 pclk = ~pclk;
	fcpwm_top i_fcpwm_top(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .prescale_ratio(prescale_ratio), .channel_out(channel_out));
	fcpwm_load i_fcpwm_load(.pclk(pclk), .clr(clr), .latch(latch),
		.channel_out(channel_out), .hi_cnt(hi_cnt));
	task stop_test;
		if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer, request held until pready is sampled high
	task xfer(input logic [7:0] idx, input logic w, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= {22'h0, idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Run with load, then poll until hardware drops the load bit
	task run_load;
		xfer(`FCPWM_IDX_CONTROL0, 1, 8'hC8);
		do xfer(`FCPWM_IDX_CONTROL0, 0, 0); while (r[6] !== 1'b0);
		chk(r, 32'hA8);
	endtask
	// High cycles of each channel over 200 clocks, ten periods
	task meas(input logic [15:0] c0, input logic [15:0] c1, input logic [15:0] c2,
		input logic [15:0] c3);
		@(posedge pclk);
		clr <= 1;
		@(posedge pclk);
		clr <= 0;
		repeat (201) @(posedge pclk);
		chk(hi_cnt, {c3, c2, c1, c0});
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		chk(channel_out, 4'hF);
		latch <= 4'hF;
		xfer(`FCPWM_IDX_CONTROL0, 1, 8'h10);
		foreach (rows[k]) begin
			xfer(rows[k][23:16], 0, 0);
			chk({e, r}, {rows[k][23:16] == 8'hC0, 32'h0});
			xfer(rows[k][23:16], 1, rows[k][15:8]);
			xfer(rows[k][23:16], 0, 0);
			chk({e, r}, {rows[k][23:16] == 8'hC0, 24'h0, rows[k][7:0]});
		end
		run_load;
		meas(200, 0, 140, 60);
		xfer(`FCPWM_IDX_DUTY2_LOW, 1, 8'h08);
		meas(200, 0, 140, 60);
		run_load;
		meas(200, 0, 40, 60);
		stop_test;
	end
	// Hang guard, well above the expected run length
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			stop_test;
		end
	end
endmodule // fcpwm_tb_top
bind fcpwm_top fcpwm_properties i_fcpwm_properties(.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .channel_out(channel_out));
